//--- pkg/adcsel_pkg.sv
// constants and types shared by the converter control block
package adcsel_pkg;

   // register byte addresses on the special function register port
   localparam logic [7:0] ADDR_INPUT_SELECT   = 8'hbb;
   localparam logic [7:0] ADDR_CONFIG         = 8'hbc;
   localparam logic [7:0] ADDR_RESULT_LOW     = 8'hbe;
   localparam logic [7:0] ADDR_RESULT_HIGH    = 8'hbf;
   localparam logic [7:0] ADDR_CONTROL        = 8'he8;

   // analog_input_select fields
   localparam int         SEL_ENABLE_BIT      = 5;
   localparam int         SEL_PORT_LSB        = 3;
   localparam int         SEL_PIN_LSB         = 0;
   localparam logic [7:0] SEL_WRITE_MASK      = 8'h3f;
   localparam logic [7:0] SEL_RESET           = 8'h00;

   // converter_config fields
   localparam int         CFG_DIV_LSB         = 0;
   localparam logic [7:0] CFG_WRITE_MASK      = 8'h07;
   localparam logic [7:0] CFG_RESET           = 8'h00;

   // converter_control fields
   localparam int         CTL_TRACK_MODE_BIT  = 6;
   localparam int         CTL_DONE_BIT        = 5;
   localparam int         CTL_BUSY_BIT        = 4;
   localparam int         CTL_START_HIGH_BIT  = 3;
   localparam int         CTL_START_LOW_BIT   = 2;
   localparam int         CTL_IRQ_EN_BIT      = 1;
   localparam logic [7:0] CTL_WRITE_MASK      = 8'h6e;
   localparam logic [7:0] CTL_RESET           = 8'h00;

   // result width and placement
   localparam int         RESULT_BITS         = 12;
   localparam logic [7:0] RESULT_RESET        = 8'h00;

   // pin geometry
   localparam int         PORT_COUNT          = 4;
   localparam int         PINS_PER_PORT       = 8;

   // timing
   localparam int         SYS_CLK_MHZ         = 100;
   localparam int         MIN_PERIOD_NS       = 10000;
   localparam int         MIN_PERIOD_CYC      =
      (MIN_PERIOD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int         TRACK_CLKS          = 3;
   localparam int         CONV_CLKS           = 16;
   localparam int         DIV_MAX_CODE        = 4;

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_CONVERT,
      ST_HOLDOFF
   } adcsel_state_t;

   // one register access from the processor
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } adcsel_sfr_t;

endpackage

//--- verilog/adcsel_clkdiv.sv
// conversion clock tick generator: system clock divided by 1..16
`timescale 1ns/10ps

module adcsel_clkdiv (
   input  wire logic       mclk_i,    // system clock
   input  wire logic       resetn_i,  // async reset, active low
   input  wire logic [2:0] div_i,     // divide code 0..4
   input  wire logic       run_i,     // count while high
   output logic            tick_o     // one cycle per conversion clock
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] limit;
   logic [2:0] code;

   // codes above the largest map to divide by 16
   assign code  = (div_i > 3'(adcsel_pkg::DIV_MAX_CODE)) ?
                  3'(adcsel_pkg::DIV_MAX_CODE) : div_i;
   assign limit = 4'((5'h01 << code) - 5'h01);
   assign tick_o = run_i && (cnt_q == limit);
   assign cnt_d = (!run_i || tick_o) ? 4'h0 : cnt_q + 4'h1;

   // prescale counter, restarts with each run
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

//--- verilog/adcsel_pinmux.sv
// analog pin routing: one-hot pin select and pull-up disable
`timescale 1ns/10ps

module adcsel_pinmux #(
   parameter int NPINS = 32           // port pins in total
) (
   input  wire logic             mclk_i,     // system clock
   input  wire logic             resetn_i,   // async reset, active low
   input  wire logic             enable_i,   // analog mux enable
   input  wire logic [4:0]       pin_idx_i,  // port and pin joined
   output logic      [NPINS-1:0] analog_o,   // pin routed to converter
   output logic      [NPINS-1:0] pullup_off_o // weak pull-up switched off
);

   logic [NPINS-1:0] hit;

   // only the one chosen pin turns analog, others stay digital
   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         assign hit[g] = enable_i && (pin_idx_i == 5'(g));  // R2 R4 R5
      end
   endgenerate

   // registered routing and pull-up control, one driver for each vector
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         analog_o     <= '0;
         pullup_off_o <= '0;
      end else begin
         analog_o     <= hit;
         pullup_off_o <= hit;  // R6
      end
   end

endmodule

//--- verilog/adcsel_top.sv
// converter control: input select, clocking, start, busy, results
`timescale 1ns/10ps

// Summary of operation
// (R1) select register top two bits read zero
// (R2) no analog pin unless mux enabled
// (R3) port field and pin field choose pin
// (R4) only the chosen pin becomes analog
// (R5) other pins of port stay digital
// (R6) analog pins get weak pull-up off
// (R7) software sets pin input mode analog
// (R8) conversion clock is system clock over 1..16
// (R9) never faster than 100 ksps
// (R10) software start by writing busy one
// (R11) timed start on each timer overflow
// (R12) busy reads one during whole conversion
// (R13) busy fall sets done, requests interrupt
// (R14) software polls done flag, not busy
// (R15) result registers loaded at conversion end
// (R16) default mode tracks except when converting
// (R17) track mode bit selects low-power tracking
// (R18) low-power software start tracks three clocks
// (R19) low-power timed start tracks three clocks
// (R20) tracking off during chip sleep
// (R21) starts while busy are ignored
// (R22) each overflow pulse starts at most one
module adcsel_top #(
   parameter int CONV_CLKS  = adcsel_pkg::CONV_CLKS,   // clocks per convert
   parameter int TRACK_CLKS = adcsel_pkg::TRACK_CLKS,  // low-power track
   parameter int MIN_CYC    = adcsel_pkg::MIN_PERIOD_CYC // start spacing
) (
   input  wire logic                   mclk_i,       // system clock
   input  wire logic                   resetn_i,     // async reset, low
   input  wire adcsel_pkg::adcsel_sfr_t sfr_i,       // register access
   output logic [7:0]                  sfr_rdata_o,  // read data, next cycle
   input  wire logic                   timer_ovf_i,  // timer overflow pulse
   input  wire logic                   sleep_i,      // chip in standby
   input  wire logic [11:0]            adc_data_i,   // converter result
   output logic [31:0]                 analog_sel_o, // pins routed analog
   output logic [31:0]                 pullup_off_o, // pull-ups disabled
   output logic                        track_o,      // track-and-hold track
   output logic                        convert_o,    // approximation running
   output logic                        conv_tick_o,  // conversion clock tick
   output logic                        busy_o,       // conversion busy
   output logic                        irq_o         // end of conversion irq
);

   // register state
   logic [7:0]                 sel_q;
   logic [7:0]                 sel_d;
   logic [7:0]                 cfg_q;
   logic [7:0]                 cfg_d;
   logic [7:0]                 ctl_q;
   logic [7:0]                 ctl_d;
   logic [7:0]                 res_lo_q;
   logic [7:0]                 res_lo_d;
   logic [7:0]                 res_hi_q;
   logic [7:0]                 res_hi_d;
   logic [7:0]                 rdata_q;
   logic [7:0]                 rdata_d;
   logic                       done_q;
   logic                       done_d;

   // sequencer state
   adcsel_pkg::adcsel_state_t  state_q;
   adcsel_pkg::adcsel_state_t  state_d;
   logic [5:0]                 clk_cnt_q;
   logic [5:0]                 clk_cnt_d;
   logic [15:0]                rate_cnt_q;
   logic [15:0]                rate_cnt_d;

   // decode wires
   logic                       wr_sel;
   logic                       wr_cfg;
   logic                       wr_ctl;
   logic                       rd_any;
   logic                       mode_timed;
   logic                       low_power;
   logic                       sw_start;
   logic                       hw_start;
   logic                       start_req;
   logic                       start_go;
   logic                       idle;
   logic                       tick;
   logic                       div_run;
   logic                       track_end;
   logic                       conv_end;
   logic                       rate_ok;
   logic                       finish;
   logic [4:0]                 pin_idx;
   logic [7:0]                 read_mux;
   logic [7:0]                 ctl_view;

   // register write decode
   assign wr_sel = sfr_i.wr && (sfr_i.addr == adcsel_pkg::ADDR_INPUT_SELECT);
   assign wr_cfg = sfr_i.wr && (sfr_i.addr == adcsel_pkg::ADDR_CONFIG);
   assign wr_ctl = sfr_i.wr && (sfr_i.addr == adcsel_pkg::ADDR_CONTROL);
   assign rd_any = sfr_i.rd;

   // mode bits from the control register
   assign mode_timed = ctl_q[adcsel_pkg::CTL_START_LOW_BIT];
   assign low_power  = ctl_q[adcsel_pkg::CTL_TRACK_MODE_BIT];  // R17
   assign idle       = (state_q == adcsel_pkg::ST_IDLE);

   // start sources, each picked by the start-mode field
   assign sw_start  = wr_ctl && !mode_timed
                      && sfr_i.wdata[adcsel_pkg::CTL_BUSY_BIT];  // R10
   assign hw_start  = timer_ovf_i && mode_timed;  // R11 R22
   assign start_req = sw_start || hw_start;
   assign start_go  = start_req && idle;  // R21

   // conversion clock divider runs only while a conversion is open
   assign div_run = !idle && (state_q != adcsel_pkg::ST_HOLDOFF);

   adcsel_clkdiv u_clkdiv (
      .mclk_i   (mclk_i),
      .resetn_i (resetn_i),
      .div_i    (cfg_q[adcsel_pkg::CFG_DIV_LSB +: 3]),  // R8
      .run_i    (div_run),
      .tick_o   (tick)
   );

   // track and convert ends counted in conversion clocks; holdoff end in system clocks
   assign track_end = tick && (state_q == adcsel_pkg::ST_TRACK)
                      && (clk_cnt_q == 6'(TRACK_CLKS - 1));  // R18 R19
   assign conv_end  = tick && (state_q == adcsel_pkg::ST_CONVERT)
                      && (clk_cnt_q == 6'(CONV_CLKS - 1));
   assign rate_ok   = (rate_cnt_q == 16'h0000);  // R9
   assign finish    = (conv_end && rate_ok)
                      || ((state_q == adcsel_pkg::ST_HOLDOFF) && rate_ok);

   // sequencer next state
   always_comb begin
      state_d   = state_q;
      clk_cnt_d = clk_cnt_q;
      unique case (state_q)
         adcsel_pkg::ST_IDLE: begin
            clk_cnt_d = 6'h00;
            if (start_go) begin
               state_d = low_power ? adcsel_pkg::ST_TRACK
                                   : adcsel_pkg::ST_CONVERT;  // R16 R17
            end
         end
         adcsel_pkg::ST_TRACK: begin
            if (track_end) begin
               state_d   = adcsel_pkg::ST_CONVERT;
               clk_cnt_d = 6'h00;
            end else if (tick) begin
               clk_cnt_d = clk_cnt_q + 6'h01;
            end
         end
         adcsel_pkg::ST_CONVERT: begin
            if (conv_end) begin
               clk_cnt_d = 6'h00;
               state_d   = rate_ok ? adcsel_pkg::ST_IDLE
                                   : adcsel_pkg::ST_HOLDOFF;  // R9
            end else if (tick) begin
               clk_cnt_d = clk_cnt_q + 6'h01;
            end
         end
         adcsel_pkg::ST_HOLDOFF: begin
            if (rate_ok) begin
               state_d = adcsel_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // start spacing counter, loaded at each accepted start
   always_comb begin
      if (start_go) begin
         rate_cnt_d = 16'(MIN_CYC - 1);  // R9
      end else if (!rate_ok) begin
         rate_cnt_d = rate_cnt_q - 16'h0001;
      end else begin
         rate_cnt_d = rate_cnt_q;
      end
   end

   // sequencer registers
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q    <= adcsel_pkg::ST_IDLE;
         clk_cnt_q  <= 6'h00;
         rate_cnt_q <= 16'h0000;
      end else begin
         state_q    <= state_d;
         clk_cnt_q  <= clk_cnt_d;
         rate_cnt_q <= rate_cnt_d;
      end
   end

   // analog input select: top two bits never stored
   assign sel_d = wr_sel ? (sfr_i.wdata & adcsel_pkg::SEL_WRITE_MASK)
                         : sel_q;  // R1
   // converter configuration: divide field only
   assign cfg_d = wr_cfg ? (sfr_i.wdata & adcsel_pkg::CFG_WRITE_MASK)
                         : cfg_q;
   // control bits kept by software; busy and done are hardware state
   assign ctl_d = wr_ctl ? (sfr_i.wdata & adcsel_pkg::CTL_WRITE_MASK)
                         : ctl_q;

   // done flag: set at busy fall wins over a software clear
   always_comb begin
      done_d = done_q;
      if (wr_ctl && !sfr_i.wdata[adcsel_pkg::CTL_DONE_BIT]) begin
         done_d = 1'b0;
      end
      if (finish) begin
         done_d = 1'b1;  // R13
      end
   end

   // result registers, right justified, loaded at conversion end
   assign res_lo_d = finish ? adc_data_i[7:0] : res_lo_q;  // R15
   assign res_hi_d = finish ? {4'h0, adc_data_i[11:8]} : res_hi_q;  // R15

   // software registers
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_q    <= adcsel_pkg::SEL_RESET;
         cfg_q    <= adcsel_pkg::CFG_RESET;
         ctl_q    <= adcsel_pkg::CTL_RESET;
         done_q   <= 1'b0;
         res_lo_q <= adcsel_pkg::RESULT_RESET;
         res_hi_q <= adcsel_pkg::RESULT_RESET;
      end else begin
         sel_q    <= sel_d;
         cfg_q    <= cfg_d;
         ctl_q    <= ctl_d;
         done_q   <= done_d;
         res_lo_q <= res_lo_d;
         res_hi_q <= res_hi_d;
      end
   end

   // control register as software sees it
   always_comb begin
      ctl_view = ctl_q;
      ctl_view[adcsel_pkg::CTL_BUSY_BIT] = !idle;  // R12
      ctl_view[adcsel_pkg::CTL_DONE_BIT] = done_q;
   end

   // read select; unmapped addresses read zero
   always_comb begin
      unique case (sfr_i.addr)
         adcsel_pkg::ADDR_INPUT_SELECT: read_mux = sel_q;  // R1
         adcsel_pkg::ADDR_CONFIG:       read_mux = cfg_q;
         adcsel_pkg::ADDR_RESULT_LOW:   read_mux = res_lo_q;
         adcsel_pkg::ADDR_RESULT_HIGH:  read_mux = res_hi_q;  // R15
         adcsel_pkg::ADDR_CONTROL:      read_mux = ctl_view;
         default:                       read_mux = 8'h00;
      endcase
   end

   assign rdata_d = rd_any ? read_mux : rdata_q;

   // read data register
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // pin index: port field above pin field
   assign pin_idx = {sel_q[adcsel_pkg::SEL_PORT_LSB +: 2],
                     sel_q[adcsel_pkg::SEL_PIN_LSB +: 3]};  // R3

   adcsel_pinmux #(
      .NPINS (adcsel_pkg::PORT_COUNT * adcsel_pkg::PINS_PER_PORT)
   ) u_pinmux (
      .mclk_i       (mclk_i),
      .resetn_i     (resetn_i),
      .enable_i     (sel_q[adcsel_pkg::SEL_ENABLE_BIT]),  // R2
      .pin_idx_i    (pin_idx),
      .analog_o     (analog_sel_o),
      .pullup_off_o (pullup_off_o)
   );

   // track-and-hold control toward the analog converter
   always_comb begin
      if (sleep_i) begin
         track_o = 1'b0;  // R20
      end else if (low_power) begin
         track_o = (state_q == adcsel_pkg::ST_TRACK);  // R18 R19
      end else begin
         track_o = (state_q != adcsel_pkg::ST_CONVERT);  // R16
      end
   end

   // status and strobes
   assign convert_o   = (state_q == adcsel_pkg::ST_CONVERT);
   assign conv_tick_o = tick;
   assign busy_o      = !idle;  // R12
   assign irq_o       = done_q && ctl_q[adcsel_pkg::CTL_IRQ_EN_BIT];  // R13
   assign sfr_rdata_o = rdata_q;

endmodule

//--- verif/adcsel_asserts.sv
// property checker for the converter control block ports
`timescale 1ns/10ps

module adcsel_asserts #(
   parameter int MIN_CYC = 1000                  // start spacing
) (
   input wire logic                    mclk_i,       // system clock
   input wire logic                    resetn_i,     // async reset
   input wire adcsel_pkg::adcsel_sfr_t sfr_i,        // register access
   input wire logic [7:0]              sfr_rdata_o,  // read data
   input wire logic                    timer_ovf_i,  // overflow pulse
   input wire logic                    sleep_i,      // chip standby
   input wire logic [11:0]             adc_data_i,   // converter data
   input wire logic [31:0]             analog_sel_o, // analog pins
   input wire logic [31:0]             pullup_off_o, // pull-ups off
   input wire logic                    track_o,      // tracking
   input wire logic                    convert_o,    // converting
   input wire logic                    conv_tick_o,  // conversion clock
   input wire logic                    busy_o,       // busy
   input wire logic                    irq_o         // interrupt
);
   logic prev_busy_q;
   logic tmode_q;
   logic ien_q;
   int   cnt_q;
   wire  ctl_wr = sfr_i.wr && (sfr_i.addr == adcsel_pkg::ADDR_CONTROL);

   // shadow of start mode, irq enable and busy length
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_busy_q <= 1'b0;
         tmode_q     <= 1'b0;
         ien_q       <= 1'b0;
         cnt_q       <= 0;
      end else begin
         prev_busy_q <= busy_o;
         cnt_q       <= busy_o ? cnt_q + 1 : 0;
         if (ctl_wr) begin
            tmode_q <= sfr_i.wdata[2];
            ien_q   <= sfr_i.wdata[1];
         end
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_sw_req;
      ctl_wr && sfr_i.wdata[4] && !tmode_q && !busy_o;
   endsequence
   sequence s_tm_req;
      timer_ovf_i && tmode_q && !ctl_wr && !busy_o;
   endsequence
   sequence s_end;
      prev_busy_q && !busy_o;
   endsequence

   property p_sel_top;
      sfr_i.rd && sfr_i.addr == adcsel_pkg::ADDR_INPUT_SELECT
         |=> sfr_rdata_o[7:6] == 2'b00;
   endproperty
   property p_one_pin;
      $onehot0(analog_sel_o);
   endproperty
   property p_pullup;
      pullup_off_o == analog_sel_o;
   endproperty
   property p_sw_start;
      s_sw_req |=> busy_o [*4];
   endproperty
   property p_tm_start;
      s_tm_req |=> busy_o [*4];
   endproperty
   property p_busy_hold;
      !prev_busy_q && busy_o |-> busy_o [*8];
   endproperty
   property p_rate;
      s_end |-> cnt_q >= MIN_CYC - 1;
   endproperty
   property p_irq_end;
      s_end ##0 ien_q |-> irq_o;
   endproperty
   property p_tick_busy;
      conv_tick_o |-> busy_o;
   endproperty
   property p_track_conv;
      convert_o |-> !track_o;
   endproperty
   property p_sleep;
      sleep_i |-> !track_o;
   endproperty

   a_sel_top: assert property (p_sel_top)
      else $error("select top bits not zero");
   a_one_pin: assert property (p_one_pin)
      else $error("more than one analog pin");
   a_pullup: assert property (p_pullup)
      else $error("pull-up state differs from analog pins");
   a_sw_start: assert property (p_sw_start)
      else $error("software start not taken");
   a_tm_start: assert property (p_tm_start)
      else $error("timer start not taken");
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped early");
   a_rate: assert property (p_rate)
      else $error("conversion faster than rate limit");
   a_irq_end: assert property (p_irq_end)
      else $error("no interrupt at conversion end");
   a_tick_busy: assert property (p_tick_busy)
      else $error("conversion tick outside busy");
   a_track_conv: assert property (p_track_conv)
      else $error("tracking while converting");
   a_sleep: assert property (p_sleep)
      else $error("tracking during sleep");
endmodule

//--- verif/adcsel_far.sv
// far side model: timer overflow source and converter data lines
`timescale 1ns/10ps

module adcsel_far (
   input  wire logic        mclk_i,   // system clock
   input  wire logic        resetn_i, // async reset, active low
   input  wire logic        fire_i,   // request one overflow
   input  wire logic        busy_i,   // conversion busy
   input  wire logic [11:0] data_i,   // value to convert
   output logic             ovf_o,    // timer overflow pulse
   output logic      [11:0] data_o    // converter result lines
);
   logic prev_q;

   // one-cycle overflow per request; data valid only while busy
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ovf_o  <= 1'b0;
         prev_q <= 1'b0;
         data_o <= 12'h000;
      end else begin
         ovf_o  <= fire_i;
         prev_q <= busy_i;
         if (busy_i && !prev_q) begin
            data_o <= data_i;
         end else if (!busy_i) begin
            data_o <= ~data_o; // idle lines keep changing
         end
      end
   end
endmodule

//--- verif/adcsel_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps

module adcsel_top_bench;
   localparam int CONV = 4;
   localparam int TRACK = 3;
   localparam int MINC = 40;
   logic                    mclk_i;
   logic                    resetn;
   adcsel_pkg::adcsel_sfr_t sfr;
   logic                    sleep, fire, ovf, busy_o, irq_o;
   logic                    track_o, convert_o, conv_tick_o;
   logic [11:0]             dat, adc;
   logic [7:0]              sfr_rdata_o;
   logic [31:0]             analog_sel_o, pullup_off_o, seed, x;
   logic [7:0]              exp_rd[$];
   int                      exp_ticks[$];
   int                      failures, total_checks, gap, ticks, cyc, last, k;
   logic                    rd_pend, pb;

   adcsel_top #(.CONV_CLKS(CONV), .TRACK_CLKS(TRACK), .MIN_CYC(MINC))
   adcsel_top_i (.mclk_i(mclk_i), .resetn_i(resetn), .sfr_i(sfr),
      .sfr_rdata_o(sfr_rdata_o), .timer_ovf_i(ovf), .sleep_i(sleep),
      .adc_data_i(adc), .analog_sel_o(analog_sel_o),
      .pullup_off_o(pullup_off_o), .track_o(track_o),
      .convert_o(convert_o), .conv_tick_o(conv_tick_o),
      .busy_o(busy_o), .irq_o(irq_o));
   adcsel_far adcsel_far_i (.mclk_i(mclk_i), .resetn_i(resetn),
      .fire_i(fire), .busy_i(busy_o), .data_i(dat), .ovf_o(ovf),
      .data_o(adc));

   function automatic logic [31:0] next();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // one register access, held until the taking edge
   task automatic acc(logic [7:0] a, logic w, logic r, logic [7:0] d);
      @(posedge mclk_i);
      sfr <= '{a, w, r, d};
      @(posedge mclk_i);
      sfr <= '{a, 1'b0, 1'b0, d};
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      acc(a, 1'b1, 1'b0, d);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      exp_rd.push_back(e);
      acc(a, 1'b0, 1'b1, seed[7:0]);
   endtask
   task automatic pulse();
      @(posedge mclk_i);
      fire <= 1'b1;
      @(posedge mclk_i);
      fire <= 1'b0;
   endtask

   // one conversion, with ignored starts while it runs
   task automatic conv(logic [2:0] d, logic tm, logic tmr, logic ien);
      logic [7:0]  c;
      logic [31:0] v;
      int          i;
      c = {1'b0, tm, 3'b000, tmr, ien, 1'b0};
      v = next();
      gap = 1 << d;
      exp_ticks.push_back(CONV + (tm ? TRACK : 0));
      wr(adcsel_pkg::ADDR_CONFIG, {5'h00, d});
      dat <= v[11:0];
      wr(adcsel_pkg::ADDR_CONTROL, c);
      if (tmr) begin
         pulse();
      end else begin
         wr(adcsel_pkg::ADDR_CONTROL, c | 8'h10);
         @(negedge mclk_i);
         chk("convert", !tm, convert_o);
         chk("track", tm, track_o);
      end
      repeat (6) @(posedge mclk_i);
      wr(adcsel_pkg::ADDR_CONTROL, c | 8'h10);
      pulse();
      for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("busy", 0, busy_o);
      chk("irq", ien, irq_o);
      if (!tm) chk("track", 1, track_o);
      rd(adcsel_pkg::ADDR_CONTROL, c | 8'h20);
      rd(adcsel_pkg::ADDR_RESULT_HIGH, {4'h0, v[11:8]});
      rd(adcsel_pkg::ADDR_RESULT_LOW, v[7:0]);
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // results watched here against the oldest note
   always @(posedge mclk_i) begin
      if (rd_pend === 1'b1) begin
         chk("read data", exp_rd.pop_front(), sfr_rdata_o);
      end
      rd_pend = sfr.rd;
      if (conv_tick_o === 1'b1) begin
         if (ticks > 0) chk("tick gap", gap, cyc - last);
         ticks++;
         last = cyc;
      end
      if (pb === 1'b1 && busy_o === 1'b0) begin
         chk("ticks", exp_ticks.pop_front(), ticks);
         ticks = 0;
      end
      pb = busy_o;
      cyc++;
   end

   initial begin
      repeat (40000) @(posedge mclk_i);
      failures++;
      conclude();
   end

   initial begin
      seed = 32'h0000_0024;
      sfr = '0;
      {sleep, fire, dat, resetn, rd_pend, pb} = '0;
      {failures, total_checks, ticks, cyc, last} = '0;
      repeat (8) @(posedge mclk_i);
      resetn <= 1'b1;
      @(negedge mclk_i);
      chk("track", 1, track_o);
      wr(adcsel_pkg::ADDR_CONFIG, 8'hff);
      rd(adcsel_pkg::ADDR_CONFIG, 8'h07);
      wr(8'hc0, 8'h55);
      rd(8'hc0, 8'h00);
      wr(adcsel_pkg::ADDR_INPUT_SELECT, 8'h3c);
      rd(adcsel_pkg::ADDR_INPUT_SELECT, 8'h3c);
      @(negedge mclk_i);
      chk("pins", 32'h1000_0000, analog_sel_o);
      for (k = 0; k < 8; k++) begin
         x = next();
         wr(adcsel_pkg::ADDR_INPUT_SELECT, x[7:0] | 8'he0);
         rd(adcsel_pkg::ADDR_INPUT_SELECT, {3'b001, x[4:0]});
         @(negedge mclk_i);
         chk("pins", 32'h0000_0001 << x[4:0], analog_sel_o);
         chk("pull", 32'h0000_0001 << x[4:0], pullup_off_o);
      end
      wr(adcsel_pkg::ADDR_INPUT_SELECT, 8'h1c);
      rd(adcsel_pkg::ADDR_INPUT_SELECT, 8'h1c);
      @(negedge mclk_i);
      chk("pins", 0, analog_sel_o);
      for (k = 0; k < 5; k++) conv(k[2:0], 1'b0, 1'b0, 1'b1);
      pulse();
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("busy", 0, busy_o);
      conv(3'h0, 1'b1, 1'b0, 1'b0);
      conv(3'h1, 1'b0, 1'b1, 1'b1);
      conv(3'h2, 1'b1, 1'b1, 1'b0);
      @(posedge mclk_i);
      sleep <= 1'b1;
      @(negedge mclk_i);
      chk("track", 0, track_o);
      @(posedge mclk_i);
      sleep <= 1'b0;
      repeat (4) @(posedge mclk_i);
      conclude();
   end
endmodule

bind adcsel_top adcsel_asserts #(.MIN_CYC(MIN_CYC)) adcsel_asserts_i (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .sfr_i(sfr_i),
   .sfr_rdata_o(sfr_rdata_o), .timer_ovf_i(timer_ovf_i),
   .sleep_i(sleep_i), .adc_data_i(adc_data_i),
   .analog_sel_o(analog_sel_o), .pullup_off_o(pullup_off_o),
   .track_o(track_o), .convert_o(convert_o), .conv_tick_o(conv_tick_o),
   .busy_o(busy_o), .irq_o(irq_o));
